/* File: common/acmp_pkg.sv */
// Package with register layout and constants of the comparator control block
package acmp_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h08;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'h09;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h0A;
	localparam int BIT_POWER_OFF = 7;
	localparam int BIT_RES6 = 6;
	localparam int BIT_RESULT = 5;
	localparam int BIT_FLAG = 4;
	localparam int BIT_IRQ_EN = 3;
	localparam int BIT_RES2 = 2;
	localparam int BIT_SEL_HI = 1;
	localparam int BIT_SEL_LO = 0;
	localparam logic RESET_POWER_OFF = 1'b0;
	localparam logic RESET_IRQ_EN = 1'b0;
	localparam logic [1:0] RESET_SEL = 2'h0;
	localparam logic [1:0] SEL_TOGGLE = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;
	localparam logic [1:0] SEL_FALL = 2'h2;
	localparam logic [1:0] SEL_RISE = 2'h3;
	localparam logic [1:0] RESET_STAT = 2'h0;
	localparam logic [1:0] RESET_MASK = 2'h0;
endpackage

/* File: rtl/acmp_ctrl.sv */
// Control, status and event logic around the analog comparator
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// RQ1: The result is high while the positive input is above the negative input.
// RQ2: Power-off bit 7 set removes comparator power and may be set any time.
// RQ3: Software clears the interrupt enable before changing the power-off bit.
// RQ4: Bits 6 and 2 always read as zero.
// RQ5: Bit 5 is read-only and shows the live comparison result.
// RQ6: Bit 4 is set when a result change matches the selected event mode.
// RQ7: The interrupt is requested only when flag, enable bit 3 and global enable are set.
// RQ8: Taking the interrupt vector clears the flag.
// RQ9: Writing one to bit 4 clears the flag, writing zero leaves it.
// RQ10: Select bits 1..0 pick toggle, reserved, falling or rising.
// RQ11: Software disables the interrupt enable before changing the select field.
// RQ12: Software avoids bit set or clear instructions that would write back the flag.
// RQ13: While powered the input pull-ups and low-level wake-ups are disabled; the code disables them only while enable bit 3 is also set.
// RQ14: The result is synchronised and edges found from two successive samples.
module acmp_ctrl (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic cmp_raw_i,
	input wire logic global_irq_en_i,
	input wire logic vector_ack_i,
	output logic cmp_irq_o,
	output logic comparator_power_off_o,
	output logic pullup_disable_o,
	output logic wake_suppress_o,
	output logic irq_o
);
	logic sync1;
	logic sync2;
	logic prev;
	logic comparator_power_off;
	logic compare_irq_enable;
	logic [1:0] compare_event_select;
	logic compare_event_flag;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [7:0] rdata;
	wire ctrl_wr;
	wire stat_wr;
	wire mask_wr;
	wire rise;
	wire fall;
	wire event_hit;
	wire flag_clr;
	wire [7:0] ctrl_view;
	wire [7:0] next_rdata;
	wire [1:0] stat_set;
	wire compare_result;
	wire [2:0] sel_hit;
	wire armed;
	logic [2:0] warm;

	// Register decode shared by the write strobes and the read mux
	function automatic logic [2:0] reg_select(input logic [7:0] addr);
		reg_select = {addr == acmp_pkg::IRQ_MASK_ADDR, addr == acmp_pkg::IRQ_STAT_ADDR,
			addr == acmp_pkg::CTRL_ADDR};
	endfunction

	assign sel_hit = reg_select(addr_i);
	assign ctrl_wr = wr_i && sel_hit[0];
	assign stat_wr = wr_i && sel_hit[1];
	assign mask_wr = wr_i && sel_hit[2];

	// RQ14: two stage synchroniser
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync1 <= cmp_raw_i;
			sync2 <= sync1;
			prev <= sync2;
		end
	end

	// RQ14: edges ignored until prev holds a real sample, so an input
	// that idles high cannot fake a rising edge right after reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			warm <= 3'h0;
		end else begin
			warm <= {warm[1:0], 1'b1};
		end
	end
	assign armed = warm[2];

	// RQ1: comparison result, held low while unpowered
	assign compare_result = sync2 & ~comparator_power_off;

	// RQ14: edges from successive samples
	assign rise = sync2 & ~prev & ~comparator_power_off & armed;
	assign fall = ~sync2 & prev & ~comparator_power_off & armed;

	// RQ10: event mode decode
	assign event_hit = (compare_event_select == acmp_pkg::SEL_TOGGLE) ? (rise | fall) :
		(compare_event_select == acmp_pkg::SEL_FALL) ? fall :
		(compare_event_select == acmp_pkg::SEL_RISE) ? rise : 1'b0;

	// RQ8: vector clear; RQ9: write-one clear
	assign flag_clr = vector_ack_i || (ctrl_wr && wdata_i[acmp_pkg::BIT_FLAG]);

	// RQ2: control fields written by software
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			comparator_power_off <= acmp_pkg::RESET_POWER_OFF;
			compare_irq_enable <= acmp_pkg::RESET_IRQ_EN;
			compare_event_select <= acmp_pkg::RESET_SEL;
		end else if (ctrl_wr) begin
			comparator_power_off <= wdata_i[acmp_pkg::BIT_POWER_OFF];
			compare_irq_enable <= wdata_i[acmp_pkg::BIT_IRQ_EN];
			compare_event_select <= wdata_i[acmp_pkg::BIT_SEL_HI:acmp_pkg::BIT_SEL_LO];
		end
	end

	// RQ6: flag set wins over clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			compare_event_flag <= 1'b0;
		end else if (event_hit) begin
			compare_event_flag <= 1'b1;
		end else if (flag_clr) begin
			compare_event_flag <= 1'b0;
		end
	end

	// RQ7: gated comparator interrupt request
	assign cmp_irq_o = compare_event_flag & compare_irq_enable & global_irq_en_i;

	// RQ13: pin functions while powered and enabled
	assign pullup_disable_o = ~comparator_power_off & compare_irq_enable;
	assign wake_suppress_o = ~comparator_power_off & compare_irq_enable;
	assign comparator_power_off_o = comparator_power_off;

	// Sticky status: bit0 event, bit1 rising edge seen
	assign stat_set = {rise, event_hit};
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat <= acmp_pkg::RESET_STAT;
			irq_mask <= acmp_pkg::RESET_MASK;
		end else begin
			irq_stat <= stat_set | (irq_stat & ~(stat_wr ? wdata_i[1:0] : 2'h0));
			if (mask_wr) begin
				irq_mask <= wdata_i[1:0];
			end
		end
	end
	assign irq_o = |(irq_stat & irq_mask);

	// RQ4: reserved bits zero; RQ5: live result in bit 5
	assign ctrl_view = {comparator_power_off, 1'b0, compare_result, compare_event_flag,
		compare_irq_enable, 1'b0, compare_event_select};
	assign next_rdata = !rd_i ? 8'h00 :
		sel_hit[0] ? ctrl_view :
		sel_hit[1] ? {6'h00, irq_stat} :
		sel_hit[2] ? {6'h00, irq_mask} : 8'h00;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end
	assign rdata_o = rdata;

	// RQ7: request follows the flag and both enables
	a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ7
		cmp_irq_o == (compare_event_flag && compare_irq_enable && global_irq_en_i))
		else $error("irq gating wrong");
	// RQ6: a rising edge in rise mode sets the flag
	a_rise_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(rise && compare_event_select == acmp_pkg::SEL_RISE) |=> compare_event_flag)
		else $error("rise did not set flag");
	// RQ10: falling mode ignores rising edges
	a_fall_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ10
		(!compare_event_flag && compare_event_select == acmp_pkg::SEL_FALL && rise
		&& !ctrl_wr) |=> !compare_event_flag)
		else $error("fall mode took rising edge");
	// RQ10: reserved mode never sets
	a_reserved_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ10
		(!compare_event_flag && compare_event_select == acmp_pkg::SEL_RESERVED)
		|=> !compare_event_flag)
		else $error("reserved mode set flag");
	// RQ8: vector clears flag without new event
	a_vector_clr: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ8
		(vector_ack_i && !event_hit) |=> !compare_event_flag)
		else $error("vector did not clear flag");
	// RQ9: write zero keeps flag
	a_wr0_keep: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ9
		(compare_event_flag && ctrl_wr && !wdata_i[acmp_pkg::BIT_FLAG] && !vector_ack_i)
		|=> compare_event_flag)
		else $error("write zero cleared flag");
	// RQ4: reserved bits read zero
	a_res_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ4
		(rd_i && addr_i == acmp_pkg::CTRL_ADDR) |=> (rdata_o[6] == 1'b0 && rdata_o[2] == 1'b0))
		else $error("reserved bit nonzero");
	// RQ5: result bit follows synchronised input
	a_live_result: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ5
		(rd_i && addr_i == acmp_pkg::CTRL_ADDR) |=> rdata_o[5] == $past(compare_result))
		else $error("result bit stale");
	// RQ2: power off blocks events
	a_power_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
		comparator_power_off |-> !event_hit)
		else $error("event while powered off");
	// RQ14: input reaches the result after two edges
	a_sync_lat: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
		(!comparator_power_off && $stable(comparator_power_off)) ##0 1 |->
		sync2 == $past(cmp_raw_i, 2) || $past(rst_i, 2))
		else $error("sync latency wrong");

	// RQ1: result follows the input two edges later while powered
	a_result_follow: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ1
		!comparator_power_off |-> (compare_result == $past(cmp_raw_i, 2))
		|| $past(rst_i) || $past(rst_i, 2))
		else $error("result does not follow input");

	// RQ2: result low while unpowered
	a_result_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
		comparator_power_off |-> !compare_result)
		else $error("result high while powered off");

	// RQ2: power bit takes the written value
	a_power_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
		ctrl_wr |=> comparator_power_off == $past(wdata_i[acmp_pkg::BIT_POWER_OFF]))
		else $error("power bit not written");

	// RQ2: power bit holds without a write
	a_power_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
		!ctrl_wr |=> $stable(comparator_power_off))
		else $error("power bit changed without write");

	// RQ2: power bit reads back
	a_power_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ2
		(rd_i && sel_hit[0]) |=> rdata_o[7] == $past(comparator_power_off))
		else $error("power bit read wrong");

	// RQ4: unmapped addresses read zero
	a_unmapped_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ4
		(rd_i && sel_hit == 3'h0) |=> rdata_o == 8'h00)
		else $error("unmapped read nonzero");

	// RQ6: flag reads back
	a_flag_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(rd_i && sel_hit[0]) |=> rdata_o[4] == $past(compare_event_flag))
		else $error("flag read wrong");

	// RQ7: enable reads back
	a_enable_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ7
		(rd_i && sel_hit[0]) |=> rdata_o[3] == $past(compare_irq_enable))
		else $error("enable read wrong");

	// RQ10: select field reads back
	a_select_read: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ10
		(rd_i && sel_hit[0]) |=> rdata_o[1:0] == $past(compare_event_select))
		else $error("select read wrong");

	// RQ6: falling edge in fall mode sets the flag
	a_fall_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(fall && compare_event_select == acmp_pkg::SEL_FALL) |=> compare_event_flag)
		else $error("fall did not set flag");

	// RQ6: any edge in toggle mode sets the flag
	a_toggle_flag: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		((rise || fall) && compare_event_select == acmp_pkg::SEL_TOGGLE)
		|=> compare_event_flag)
		else $error("toggle did not set flag");

	// RQ10: rise mode ignores falling edges
	a_rise_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ10
		(!compare_event_flag && compare_event_select == acmp_pkg::SEL_RISE && fall)
		|=> !compare_event_flag)
		else $error("rise mode took falling edge");

	// RQ6: flag is sticky until cleared
	a_flag_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(compare_event_flag && !flag_clr) |=> compare_event_flag)
		else $error("flag dropped without clear");

	// RQ6: flag rises only on an event
	a_flag_source: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(!compare_event_flag && !event_hit) |=> !compare_event_flag)
		else $error("flag set without event");

	// RQ9: write of one clears the flag
	a_w1c_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ9
		(ctrl_wr && wdata_i[acmp_pkg::BIT_FLAG] && !event_hit) |=> !compare_event_flag)
		else $error("write one did not clear flag");

	// RQ6: event beats a clear in the same cycle
	a_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		(event_hit && flag_clr) |=> compare_event_flag)
		else $error("clear beat event");

	// RQ7: no request without global enable
	a_global_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ7
		!global_irq_en_i |-> !cmp_irq_o)
		else $error("request without global enable");

	// RQ7: no request without local enable
	a_enable_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ7
		!compare_irq_enable |-> !cmp_irq_o)
		else $error("request without enable");

	// RQ13: pins untouched while unpowered
	a_pins_off: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ13
		comparator_power_off |-> !pullup_disable_o && !wake_suppress_o)
		else $error("pin control while powered off");

	// RQ13: pins taken while powered and enabled
	a_pins_on: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ13
		(!comparator_power_off && compare_irq_enable) |-> pullup_disable_o && wake_suppress_o)
		else $error("pin control missing");

	// RQ14: never both edges at once
	a_edge_onehot: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
		!(rise && fall))
		else $error("rise and fall together");

	// RQ14: no event while the edge stage fills after reset
	a_no_reset_edge: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
		($past(rst_i) || $past(rst_i, 2) || $past(rst_i, 3)) |-> !event_hit)
		else $error("false edge after reset");

	// RQ14: each rising edge gives a one-cycle rise pulse
	a_edge_once: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
		rise |=> !rise)
		else $error("rising edge seen twice");

	// RQ6: event sets sticky status bit 0
	a_stat_event: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ6
		event_hit |=> irq_stat[0])
		else $error("status event bit not set");

	// RQ14: rising edge sets sticky status bit 1
	a_stat_rise: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ14
		rise |=> irq_stat[1])
		else $error("status rise bit not set");

	// RQ9: write of one clears status bit 0
	a_stat_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RQ9
		(stat_wr && wdata_i[0] && !event_hit) |=> !irq_stat[0])
		else $error("status bit not cleared");

	c_fall_stat: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		fall ##1 irq_stat[0]);
	c_rise_irq: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		rise ##1 cmp_irq_o);
	c_toggle: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		(compare_event_select == acmp_pkg::SEL_TOGGLE && fall) ##1 compare_event_flag);
	c_vector: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		compare_event_flag && vector_ack_i);
	c_wr_clear: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		compare_event_flag && flag_clr && !vector_ack_i);
endmodule // acmp_ctrl

/* File: tb/acmp_cpu_model.sv */
// Processor interrupt side model: takes the comparator vector
`timescale 1ns/1ps
module acmp_cpu_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ack_en_i,
	input wire logic cmp_irq_i,
	output logic vector_ack_o
);
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			vector_ack_o <= 1'b0;
		else
			vector_ack_o <= !vector_ack_o && ack_en_i && cmp_irq_i;
	end
endmodule // acmp_cpu_model

/* File: tb/acmp_ctrl_tb_top.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module acmp_ctrl_tb_top;
	logic sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, raw_i = 0, glb = 0, ack_en = 0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, d;
	logic vack, cirq, pwr, pud, wks, irq;
	int bad_count = 0, tests_run = 0, cyc = 0;
	localparam logic [7:0] C = acmp_pkg::CTRL_ADDR;
	always #4 sys_clk_i = ~sys_clk_i;
	acmp_ctrl acmp_ctrl_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(raw_i),
		.global_irq_en_i(glb), .vector_ack_i(vack), .cmp_irq_o(cirq),
		.comparator_power_off_o(pwr), .pullup_disable_o(pud), .wake_suppress_o(wks),
		.irq_o(irq));
	acmp_cpu_model acmp_cpu_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.ack_en_i(ack_en), .cmp_irq_i(cirq), .vector_ack_o(vack));
	// whole-byte writes only, no write-back of a pending flag
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	// Synchroniser plus edge stage settle well inside five edges
	task raw(input logic v);
		@(posedge sys_clk_i);
		raw_i <= v;
		repeat (5) @(posedge sys_clk_i);
	endtask
	task t_reset;
		rd(C);
		`CHK(d, 8'h00)
		rd(8'h3F);
		`CHK(d, 8'h00)
	endtask
	task t_modes;
		logic [1:0] s;
		for (int i = 0; i < 4; i++) begin
			s = i[1:0];
			// select changes only with enable clear
			wr(C, {6'h04, s});
			raw(1'b1);
			rd(C);
			`CHK(d, {3'b001, s == 2'h0 || s == 2'h3, 2'b00, s})
			wr(C, {6'h04, s});
			raw(1'b0);
			rd(C);
			`CHK(d, {3'b000, s == 2'h0 || s == 2'h2, 2'b00, s})
		end
	endtask
	task t_w1c;
		wr(C, 8'h10);
		raw(1'b1);
		wr(C, 8'h00);
		rd(C);
		`CHK(d, 8'h30)
		wr(C, 8'h10);
		rd(C);
		`CHK(d, 8'h20)
	endtask
	task t_irq;
		wr(C, 8'h18);
		raw(1'b0);
		`CHK(cirq, 1'b0)
		`CHK(pud & wks, 1'b1)
		@(posedge sys_clk_i);
		glb <= 1'b1;
		@(posedge sys_clk_i);
		#1 `CHK(cirq, 1'b1)
		ack_en <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		ack_en <= 1'b0;
		rd(C);
		`CHK(d, 8'h08)
		wr(C, 8'h10);
	endtask
	task t_power;
		wr(C, 8'h80);
		raw(1'b1);
		`CHK(pwr, 1'b1)
		`CHK(pud, 1'b0)
		rd(C);
		`CHK(d, 8'h80)
		wr(C, 8'h10);
		raw(1'b1);
		rd(C);
		`CHK(d, 8'h20)
	endtask
	task t_stat;
		wr(acmp_pkg::IRQ_MASK_ADDR, 8'h01);
		wr(acmp_pkg::IRQ_STAT_ADDR, 8'h03);
		rd(acmp_pkg::IRQ_STAT_ADDR);
		`CHK(d, 8'h00)
		raw(1'b0);
		`CHK(irq, 1'b1)
		rd(acmp_pkg::IRQ_STAT_ADDR);
		`CHK(d, 8'h01)
		rd(acmp_pkg::IRQ_MASK_ADDR);
		`CHK(d, 8'h01)
		raw(1'b1);
		rd(acmp_pkg::IRQ_STAT_ADDR);
		`CHK(d, 8'h03)
		wr(acmp_pkg::IRQ_MASK_ADDR, 8'h00);
		#1 `CHK(irq, 1'b0)
		wr(acmp_pkg::IRQ_MASK_ADDR, 8'h01);
		wr(acmp_pkg::IRQ_STAT_ADDR, 8'h01);
		#1 `CHK(irq, 1'b0)
		rd(acmp_pkg::IRQ_STAT_ADDR);
		`CHK(d, 8'h02)
	endtask
	// Mid-run reset with the input high must not fake an edge
	task t_rst_mid;
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		rd(C);
		`CHK(d, 8'h20)
		rd(acmp_pkg::IRQ_STAT_ADDR);
		`CHK(d, 8'h00)
		`CHK(irq | cirq, 1'b0)
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Whole sequence needs well under a thousand cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_modes();
		t_w1c();
		t_irq();
		t_power();
		t_stat();
		t_rst_mid();
		finish_test();
	end
endmodule // acmp_ctrl_tb_top
